/* core/sdbcs_bank_fsm.sv */
// One bank's state machine with its recovery and burst counters
`timescale 1ns/1ps
module sdbcs_bank_fsm (
    input wire logic core_clk, // Core clock
    input wire logic rst, // Async reset, active high
    sdbcs_bank_if.bank link // Legal commands in, state out
);
    import sdbcs_pkg::*;

    localparam int PRE_WAIT = PRECHARGE_RECOVERY_CYC;
    localparam int ACT_WAIT = ACTIVATE_TO_ACCESS_CYC;
    localparam int AP_WAIT = PRECHARGE_RECOVERY_CYC - 1;

    sdbcs_bank_state_type state_reg, state_next, burstTarget;
    logic [CNT_BITS-1:0] waitCnt_reg, waitCnt_next, beats_reg, beats_next;
    logic recover_reg, recover_next;

    // ==========================================================
    // Decode
    wire startBurst = link.readGo | link.writeGo;
    wire cut = link.stopGo | link.cutGo;
    wire waitDone = waitCnt_reg <= CNT_BITS'(1);
    wire beatsDone = beats_reg == '0;
    wire isAp = (state_reg == BK_READ_AP) || (state_reg == BK_WRITE_AP);
    assign burstTarget = link.readGo ? (link.autoPre ? BK_READ_AP : BK_READ)
                                     : (link.autoPre ? BK_WRITE_AP : BK_WRITE);
    assign link.state = state_reg;
    assign link.burstRun = (state_reg == BK_READ) || (state_reg == BK_WRITE) ||
                           (isAp && !recover_reg);

    // ==========================================================
    // Next state; only legal commands reach this bank
    always_comb begin
        state_next = state_reg;
        waitCnt_next = (waitCnt_reg == '0) ? waitCnt_reg : waitCnt_reg - CNT_BITS'(1);
        beats_next = beatsDone ? beats_reg : beats_reg - CNT_BITS'(1);
        recover_next = recover_reg;
        case (state_reg)
            BK_IDLE: begin
                // Precharge to an idle bank falls through untouched
                if (link.actGo) begin
                    state_next = BK_OPENING;
                    waitCnt_next = ACT_LOAD;
                end
            end
            BK_OPENING: begin
                if (waitDone) begin
                    state_next = BK_ACTIVE;
                end
            end
            BK_ACTIVE, BK_READ, BK_WRITE: begin
                if (startBurst) begin
                    state_next = burstTarget;
                    beats_next = BURST_LOAD;
                    waitCnt_next = PRE_LOAD;
                    recover_next = 1'b0;
                end else if (link.preGo) begin
                    state_next = BK_CLOSING;
                    waitCnt_next = PRE_LOAD;
                end else if (state_reg != BK_ACTIVE && (cut || beatsDone)) begin
                    state_next = BK_ACTIVE;
                end
            end
            BK_READ_AP, BK_WRITE_AP: begin
                // Recovery count waits for the burst to end or be cut
                if (!recover_reg) begin
                    waitCnt_next = waitCnt_reg;
                    recover_next = cut || beatsDone;
                end else if (waitDone) begin
                    state_next = BK_IDLE;
                    recover_next = 1'b0;
                end
            end
            BK_CLOSING: begin
                if (waitDone) begin
                    state_next = BK_IDLE;
                end
            end
            default: state_next = BK_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= BK_IDLE;
            waitCnt_reg <= '0;
            beats_reg <= '0;
            recover_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            waitCnt_reg <= waitCnt_next;
            beats_reg <= beats_next;
            recover_reg <= recover_next;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    act_opens_row_a: assert property (
        link.actGo |-> ##1 state_reg == BK_OPENING ##(ACT_WAIT - 1) state_reg == BK_ACTIVE
    ) else $error("activate did not open the row on time");

    idle_after_pre_a: assert property (
        link.preGo && state_reg != BK_IDLE |-> ##PRE_WAIT state_reg == BK_IDLE
    ) else $error("bank not idle once precharge recovery elapsed");

    pre_on_idle_a: assert property (
        link.preGo && state_reg == BK_IDLE |=> state_reg == BK_IDLE
    ) else $error("precharge changed an idle bank");

    read_start_a: assert property (
        link.readGo && !link.autoPre |=> state_reg == BK_READ && link.burstRun
    ) else $error("read did not start a burst");

    write_start_a: assert property (
        link.writeGo && !link.autoPre |=> state_reg == BK_WRITE && link.burstRun
    ) else $error("write did not start a burst");

    pre_truncates_a: assert property (
        link.preGo && link.burstRun |=> state_reg == BK_CLOSING && !link.burstRun
    ) else $error("precharge did not truncate the burst");

    ap_holds_a: assert property (
        $rose(recover_reg) |-> isAp [*1] ##(AP_WAIT) state_reg == BK_IDLE
    ) else $error("auto precharge did not end in idle after recovery");

    ap_select_a: assert property (
        startBurst && link.autoPre |=> isAp && !recover_reg
    ) else $error("auto precharge bit not honoured");
endmodule

/* core/sdbcs_bank_if.sv */
// Command strobes and state exchanged between the decoder and one bank
`timescale 1ns/1ps
interface sdbcs_bank_if;
    import sdbcs_pkg::*;
    logic actGo;
    logic readGo;
    logic writeGo;
    logic preGo;
    logic stopGo;
    logic cutGo;
    logic autoPre;
    sdbcs_bank_state_type state;
    logic burstRun;
    modport ctrl (output actGo, readGo, writeGo, preGo, stopGo, cutGo, autoPre,
                  input state, burstRun);
    modport bank (input actGo, readGo, writeGo, preGo, stopGo, cutGo, autoPre,
                  output state, burstRun);
endinterface

/* core/sdbcs_command_state.sv */
// Command decoder and bank state tracker for a four-bank SDRAM
`timescale 1ns/1ps
module sdbcs_command_state (
    input wire logic core_clk, // 125 MHz core clock
    input wire logic rst, // Async reset, active high
    input wire logic sdramCsN, // Chip select pin
    input wire logic sdramRasN, // Row strobe pin
    input wire logic sdramCasN, // Column strobe pin
    input wire logic sdramWeN, // Write enable pin
    input wire logic [sdbcs_pkg::ADDR_BITS-1:0] sdramAddr, // Address pins
    input wire logic bankSelectLo, // Bank select, low bit
    input wire logic bankSelectHi, // Bank select, high bit
    output sdbcs_pkg::sdbcs_bank_state_type bankState [sdbcs_pkg::BANK_COUNT], // Per bank
    output sdbcs_pkg::sdbcs_dev_state_type deviceState, // Device-wide phase
    output logic allBanksIdle, // Every bank idle
    output logic cmdTaken, // Pulse: command executed
    output logic cmdIllegal, // Pulse: command refused
    output logic burstLive, // Most recent burst still running
    output logic [sdbcs_pkg::BANK_BITS-1:0] burstBank // Bank of most recent burst
);
    import sdbcs_pkg::*;

    localparam int PRE_WAIT = PRECHARGE_RECOVERY_CYC;
    localparam int REF_WAIT = REFRESH_CYCLE_CYC;
    localparam int MODE_WAIT = MODE_LOAD_DELAY_CYC;

    // ==========================================================
    // Pin synchroniser
    logic [PIN_BITS-1:0] pinMeta_reg, pinSync_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pinMeta_reg <= PIN_IDLE;
            pinSync_reg <= PIN_IDLE;
        end else begin
            pinMeta_reg <= {sdramCsN, sdramRasN, sdramCasN, sdramWeN,
                            bankSelectHi, bankSelectLo, sdramAddr};
            pinSync_reg <= pinMeta_reg;
        end
    end

    // ==========================================================
    // Command decode
    wire [3:0] cmdCode = pinSync_reg[CMD_LSB +: 4];
    wire [BANK_BITS-1:0] selBank = pinSync_reg[BANK_LSB +: BANK_BITS];
    wire autoPrechargeSelectBit = pinSync_reg[AP_BIT];
    wire isInhibit = cmdCode[3];
    wire isNop = cmdCode == CMD_NOP;
    wire isAct = cmdCode == CMD_ACT;
    wire isRead = cmdCode == CMD_READ;
    wire isWrite = cmdCode == CMD_WRITE;
    wire isPre = cmdCode == CMD_PRE;
    wire isRef = cmdCode == CMD_REF;
    wire isMode = cmdCode == CMD_MODE;
    wire isStop = cmdCode == CMD_STOP;

    sdbcs_dev_state_type devState_reg, devState_next;
    logic [CNT_BITS-1:0] devCnt_reg, devCnt_next;
    logic [BANK_BITS-1:0] lastBank_reg;
    logic cmdTaken_reg, cmdIllegal_reg;
    wire devReady = devState_reg == DEV_READY;

    // ==========================================================
    // Per-bank legality and bank instances
    logic [BANK_COUNT-1:0] idleVec, activeVec, burstVec, preOkVec, runVec;
    logic [BANK_COUNT-1:0] actGoVec, readGoVec, writeGoVec, preGoVec, stopGoVec;
    wire allPreOk = &preOkVec;
    wire anyAccess = |(readGoVec | writeGoVec);

    sdbcs_bank_if bankLink [BANK_COUNT] ();

    genvar gi;
    generate
        for (gi = 0; gi < BANK_COUNT; gi++) begin : g_bank
            wire hit = selBank == BANK_BITS'(gi);
            assign idleVec[gi] = bankLink[gi].state == BK_IDLE;
            assign activeVec[gi] = bankLink[gi].state == BK_ACTIVE;
            assign burstVec[gi] = (bankLink[gi].state == BK_READ) ||
                                  (bankLink[gi].state == BK_WRITE);
            assign preOkVec[gi] = idleVec[gi] | activeVec[gi] | burstVec[gi];
            assign runVec[gi] = bankLink[gi].burstRun;
            // Other banks' states gate a bank's own commands only through precharge-all
            assign actGoVec[gi] = devReady & isAct & hit & idleVec[gi];
            assign readGoVec[gi] = devReady & isRead & hit &
                                   (activeVec[gi] | burstVec[gi]);
            assign writeGoVec[gi] = devReady & isWrite & hit &
                                    (activeVec[gi] | burstVec[gi]);
            assign preGoVec[gi] = devReady & isPre & (autoPrechargeSelectBit ? allPreOk
                                  : hit & preOkVec[gi]);
            assign stopGoVec[gi] = devReady & isStop & runVec[gi] &
                                   (lastBank_reg == BANK_BITS'(gi));
            assign bankLink[gi].actGo = actGoVec[gi];
            assign bankLink[gi].readGo = readGoVec[gi];
            assign bankLink[gi].writeGo = writeGoVec[gi];
            assign bankLink[gi].preGo = preGoVec[gi];
            assign bankLink[gi].stopGo = stopGoVec[gi];
            // A burst started elsewhere cuts this bank's burst
            assign bankLink[gi].cutGo = anyAccess & !hit;
            assign bankLink[gi].autoPre = autoPrechargeSelectBit;
            assign bankState[gi] = bankLink[gi].state;

            sdbcs_bank_fsm u_bank (
                .core_clk(core_clk),
                .rst(rst),
                .link(bankLink[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Device-wide phases
    wire refreshTake = devReady & isRef & allBanksIdle;
    wire modeTake = devReady & isMode & allBanksIdle;
    wire preAllTake = devReady & isPre & autoPrechargeSelectBit & allPreOk;
    wire anyGo = |{actGoVec, readGoVec, writeGoVec, preGoVec, stopGoVec};
    wire cmdLegal = anyGo | refreshTake | modeTake;
    wire quietCmd = isInhibit | isNop;
    wire devWaitDone = devCnt_reg <= CNT_BITS'(1);

    always_comb begin
        devState_next = devState_reg;
        devCnt_next = (devCnt_reg == '0) ? devCnt_reg : devCnt_reg - CNT_BITS'(1);
        case (devState_reg)
            DEV_READY: begin
                if (refreshTake) begin
                    devState_next = DEV_REFRESH;
                    devCnt_next = REF_LOAD;
                end else if (modeTake) begin
                    devState_next = DEV_MODE;
                    devCnt_next = MODE_LOAD;
                end else if (preAllTake) begin
                    devState_next = DEV_PREALL;
                    devCnt_next = PRE_LOAD;
                end
            end
            DEV_REFRESH, DEV_MODE, DEV_PREALL: begin
                if (devWaitDone) begin
                    devState_next = DEV_READY;
                end
            end
            default: devState_next = DEV_READY;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            devState_reg <= DEV_READY;
            devCnt_reg <= '0;
        end else begin
            devState_reg <= devState_next;
            devCnt_reg <= devCnt_next;
        end
    end

    // ==========================================================
    // Burst ownership and command verdict
    // Anything outside the tables is flagged and dropped
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lastBank_reg <= '0;
            cmdTaken_reg <= 1'b0;
            cmdIllegal_reg <= 1'b0;
        end else begin
            if (anyAccess) begin
                lastBank_reg <= selBank;
            end
            cmdTaken_reg <= !quietCmd & cmdLegal;
            cmdIllegal_reg <= !quietCmd & !cmdLegal;
        end
    end

    assign deviceState = devState_reg;
    assign allBanksIdle = &idleVec;
    assign cmdTaken = cmdTaken_reg;
    assign cmdIllegal = cmdIllegal_reg;
    assign burstBank = lastBank_reg;
    assign burstLive = runVec[lastBank_reg];

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    inhibit_quiet_a: assert property (
        isInhibit |-> !anyGo && !refreshTake && !modeTake ##1 !cmdIllegal && !cmdTaken
    ) else $error("inhibit cycle acted on the command lines");

    nop_quiet_a: assert property (
        isNop |-> !anyGo ##1 !cmdTaken && !cmdIllegal
    ) else $error("no-operation started a command");

    refresh_hold_a: assert property (
        refreshTake |-> ##1 devState_reg == DEV_REFRESH ##(REF_WAIT - 1) devReady
    ) else $error("refresh phase length wrong");

    refresh_all_idle_a: assert property (
        (isRef || isMode) && !allBanksIdle |-> !refreshTake && !modeTake ##1 cmdIllegal
    ) else $error("device-wide command taken with a bank open");

    mode_hold_a: assert property (
        modeTake |-> ##1 devState_reg == DEV_MODE ##(MODE_WAIT - 1) devReady && allBanksIdle
    ) else $error("mode load phase length wrong");

    preall_idle_a: assert property (
        preAllTake |-> ##PRE_WAIT devReady && allBanksIdle
    ) else $error("banks not idle after precharge-all recovery");

    single_pre_a: assert property (
        isPre && !autoPrechargeSelectBit |-> (preGoVec & ~(BANK_COUNT'(1) << selBank)) == '0
    ) else $error("single-bank precharge reached another bank");

    stop_last_a: assert property (
        |stopGoVec |-> stopGoVec == (BANK_COUNT'(1) << lastBank_reg) ##1 !burstLive
    ) else $error("burst terminate missed the most recent burst");

    // ==========================================================
    // Verdict on every decoded command
    busy_refuse_a: assert property (
        !devReady && !quietCmd
        |=> cmdIllegal
    ) else $error("command taken during a device-wide wait");

    act_refuse_a: assert property (
        isAct && !idleVec[selBank]
        |=> cmdIllegal
    ) else $error("activate taken by a bank that is not idle");

    act_take_a: assert property (
        devReady && isAct && idleVec[selBank]
        |=> cmdTaken && bankState[$past(selBank)] == BK_OPENING
    ) else $error("activate to an idle bank not taken");

    access_refuse_a: assert property (
        (isRead || isWrite) && !activeVec[selBank] && !burstVec[selBank]
        |=> cmdIllegal
    ) else $error("access taken by a bank without an open row");

    access_take_a: assert property (
        devReady && (isRead || isWrite) && (activeVec[selBank] || burstVec[selBank])
        |=> cmdTaken && burstLive && burstBank == $past(selBank)
    ) else $error("access to an open row not taken");

    stop_refuse_a: assert property (
        isStop && !runVec[lastBank_reg]
        |=> cmdIllegal
    ) else $error("burst terminate taken with no burst running");

    stop_take_a: assert property (
        devReady && isStop && runVec[lastBank_reg]
        |=> cmdTaken && !burstLive
    ) else $error("burst terminate not taken");

    pre_refuse_a: assert property (
        isPre && !autoPrechargeSelectBit && !preOkVec[selBank]
        |=> cmdIllegal
    ) else $error("precharge taken by a bank in a transient state");

    pre_idle_take_a: assert property (
        devReady && isPre && !autoPrechargeSelectBit && idleVec[selBank]
        |=> cmdTaken && bankState[$past(selBank)] == BK_IDLE
    ) else $error("precharge to an idle bank not a no-operation");

    preall_refuse_a: assert property (
        devReady && isPre && autoPrechargeSelectBit && !allPreOk
        |=> cmdIllegal && devReady
    ) else $error("precharge-all taken with a bank in a transient state");

    cut_other_a: assert property (
        anyAccess && burstVec[lastBank_reg] && selBank != lastBank_reg
        |=> bankState[$past(lastBank_reg)] == BK_ACTIVE
    ) else $error("access to another bank left the old burst running");

    device_take_a: assert property (
        devReady && (isRef || isMode) && allBanksIdle
        |=> cmdTaken && !devReady
    ) else $error("device-wide command refused with all banks idle");
endmodule

/* core/sdbcs_pkg.sv */
// Shared constants and types for the SDRAM bank command and state tracker
package sdbcs_pkg;
    // ==========================================================
    // Geometry and pin bundle layout
    localparam int BANK_COUNT = 4;
    localparam int BANK_BITS = 2;
    localparam int ADDR_BITS = 12;
    localparam int AP_BIT = 10;
    localparam int BANK_LSB = 12;
    localparam int CMD_LSB = 14;
    localparam int PIN_BITS = 18;
    localparam logic [PIN_BITS-1:0] PIN_IDLE = 18'h3FFFF;

    // ==========================================================
    // Command codes as {cs, ras, cas, we}, all active low
    localparam logic [3:0] CMD_MODE = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_STOP = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;

    // ==========================================================
    // Timing; every cycle count must come out at two or more
    localparam int CORE_CLK_MHZ = 125;
    localparam int PRECHARGE_RECOVERY_NS = 20;
    localparam int ACTIVATE_TO_ACCESS_NS = 20;
    localparam int REFRESH_CYCLE_NS = 70;
    localparam int MODE_LOAD_DELAY_CYC = 2;
    localparam int BURST_BEATS = 4;
    localparam int CNT_BITS = 8;

    function automatic int ns_to_cyc(input int ns);
        int cyc;
        cyc = (ns * CORE_CLK_MHZ + 999) / 1000;
        return (cyc < 1) ? 1 : cyc;
    endfunction

    localparam int PRECHARGE_RECOVERY_CYC = ns_to_cyc(PRECHARGE_RECOVERY_NS);
    localparam int ACTIVATE_TO_ACCESS_CYC = ns_to_cyc(ACTIVATE_TO_ACCESS_NS);
    localparam int REFRESH_CYCLE_CYC = ns_to_cyc(REFRESH_CYCLE_NS);
    localparam logic [CNT_BITS-1:0] PRE_LOAD = CNT_BITS'(PRECHARGE_RECOVERY_CYC - 1);
    localparam logic [CNT_BITS-1:0] ACT_LOAD = CNT_BITS'(ACTIVATE_TO_ACCESS_CYC - 1);
    localparam logic [CNT_BITS-1:0] REF_LOAD = CNT_BITS'(REFRESH_CYCLE_CYC - 1);
    localparam logic [CNT_BITS-1:0] MODE_LOAD = CNT_BITS'(MODE_LOAD_DELAY_CYC - 1);
    localparam logic [CNT_BITS-1:0] BURST_LOAD = CNT_BITS'(BURST_BEATS - 1);

    // ==========================================================
    // State encodings
    typedef enum logic [7:0] {
        BK_IDLE = 8'h01,
        BK_OPENING = 8'h02,
        BK_ACTIVE = 8'h04,
        BK_READ = 8'h08,
        BK_WRITE = 8'h10,
        BK_READ_AP = 8'h20,
        BK_WRITE_AP = 8'h40,
        BK_CLOSING = 8'h80
    } sdbcs_bank_state_type;

    typedef enum logic [3:0] {
        DEV_READY = 4'h1,
        DEV_REFRESH = 4'h2,
        DEV_MODE = 4'h4,
        DEV_PREALL = 4'h8
    } sdbcs_dev_state_type;
endpackage

/* verif/sdbcs_command_state_tb.sv */
// Self-checking bench for the bank command and state tracker
`timescale 1ns/1ps
module sdbcs_command_state_tb;
    import sdbcs_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic csN, rasN, casN, weN, bankLo, bankHi;
    logic [ADDR_BITS-1:0] addr;
    sdbcs_bank_state_type bankState [BANK_COUNT];
    sdbcs_dev_state_type deviceState;
    logic allBanksIdle, cmdTaken, cmdIllegal, burstLive;
    logic [BANK_BITS-1:0] burstBank;
    int errTotal = 0;
    int checks = 0;
    always #4 core_clk = ~core_clk;
    sdbcs_ctrl_model i_sdbcs_ctrl_model (.core_clk(core_clk), .csN(csN), .rasN(rasN),
        .casN(casN), .weN(weN), .addr(addr), .bankLo(bankLo), .bankHi(bankHi));
    sdbcs_command_state i_sdbcs_command_state (.core_clk(core_clk), .rst(rst),
        .sdramCsN(csN), .sdramRasN(rasN), .sdramCasN(casN), .sdramWeN(weN),
        .sdramAddr(addr), .bankSelectLo(bankLo), .bankSelectHi(bankHi),
        .bankState(bankState), .deviceState(deviceState), .allBanksIdle(allBanksIdle),
        .cmdTaken(cmdTaken), .cmdIllegal(cmdIllegal), .burstLive(burstLive),
        .burstBank(burstBank));
    // ==========================================
    // Helpers
    task automatic final_report();
        $display("checks %0d errors %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    function automatic logic [7:0] cur(input int w);
        return (w < 4) ? bankState[w] : {4'h0, deviceState};
    endfunction
    // Counts the cycles a state stands; stops on the first other sample once the state has been seen
    task automatic hold_len(input string name, input int w, input logic [7:0] st, input int exp);
        int n;
        int t;
        n = 0;
        for (t = 0; t < 60; t++) begin
            if (cur(w) === st) begin
                n++;
            end else if (n > 0) begin
                break;
            end
            @(posedge core_clk);
            #1;
        end
        if (t == 60) begin
            errTotal++;
            final_report();
        end
        check(name, 8'(n), 8'(exp));
    endtask
    // Response byte: taken pulses high nibble, refused pulses low nibble
    task automatic resp(input string name, input logic [7:0] exp);
        int tk;
        int il;
        tk = 0;
        il = 0;
        repeat (4) begin
            @(posedge core_clk);
            #1;
            tk += int'(cmdTaken === 1'b1);
            il += int'(cmdIllegal === 1'b1);
        end
        check(name, {tk[3:0], il[3:0]}, exp);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        for (int b = 0; b < 4; b++) check("bankIdle", bankState[b], BK_IDLE);
        check("devReady", {4'h0, deviceState}, {4'h0, DEV_READY});
        check("allIdle", {7'h0, allBanksIdle}, 8'h01);
    endtask
    task automatic t_quiet();
        i_sdbcs_ctrl_model.issue(4'hB, 2'h0, 1'b0);
        resp("inhibit", 8'h00);
        i_sdbcs_ctrl_model.issue(CMD_NOP, 2'h0, 1'b0);
        resp("nop", 8'h00);
        check("quietIdle", bankState[0], BK_IDLE);
    endtask
    task automatic t_act();
        fork
            begin
                i_sdbcs_ctrl_model.issue(CMD_ACT, 2'h1, 1'b0);
                i_sdbcs_ctrl_model.issue(CMD_ACT, 2'h0, 1'b0);
            end
            hold_len("opening", 1, BK_OPENING, ACTIVATE_TO_ACCESS_CYC - 1);
        join
        repeat (4) @(posedge core_clk);
        #1;
        check("b1Active", bankState[1], BK_ACTIVE);
        check("b0Active", bankState[0], BK_ACTIVE);
        i_sdbcs_ctrl_model.issue(CMD_ACT, 2'h1, 1'b0);
        resp("actBusy", 8'h01);
        i_sdbcs_ctrl_model.issue(CMD_REF, 2'h0, 1'b0);
        resp("refBusy", 8'h01);
    endtask
    task automatic t_bursts();
        fork
            i_sdbcs_ctrl_model.issue(CMD_READ, 2'h1, 1'b0);
            hold_len("read", 1, BK_READ, BURST_BEATS);
        join
        check("rdBank", {6'h0, burstBank}, 8'h01);
        fork
            begin
                i_sdbcs_ctrl_model.issue(CMD_READ, 2'h1, 1'b0);
                i_sdbcs_ctrl_model.issue(CMD_READ, 2'h1, 1'b0);
                check("liveRd", {7'h0, burstLive}, 8'h01);
            end
            hold_len("reread", 1, BK_READ, BURST_BEATS + 2);
        join
        fork
            begin
                i_sdbcs_ctrl_model.issue(CMD_WRITE, 2'h1, 1'b0);
                i_sdbcs_ctrl_model.issue(CMD_PRE, 2'h1, 1'b0);
            end
            begin
                hold_len("writeCut", 1, BK_WRITE, 2);
                hold_len("closing", 1, BK_CLOSING, PRECHARGE_RECOVERY_CYC - 1);
            end
        join
        check("b1Idle", bankState[1], BK_IDLE);
        fork
            i_sdbcs_ctrl_model.issue(CMD_READ, 2'h0, 1'b1);
            hold_len("readAp", 0, BK_READ_AP,
                     BURST_BEATS + PRECHARGE_RECOVERY_CYC - 1);
        join
        check("b0Idle", bankState[0], BK_IDLE);
    endtask
    task automatic t_stop_all();
        i_sdbcs_ctrl_model.issue(CMD_ACT, 2'h2, 1'b0);
        repeat (6) @(posedge core_clk);
        #1;
        fork
            begin
                i_sdbcs_ctrl_model.issue(CMD_READ, 2'h2, 1'b0);
                i_sdbcs_ctrl_model.issue(CMD_STOP, 2'h0, 1'b0);
            end
            hold_len("stopped", 2, BK_READ, 2);
        join
        check("stopBank", {6'h0, burstBank}, 8'h02);
        check("stopLive", {7'h0, burstLive}, 8'h00);
        check("stopAct", bankState[2], BK_ACTIVE);
        fork
            i_sdbcs_ctrl_model.issue(CMD_PRE, 2'h0, 1'b1);
            hold_len("preAll", 4, {4'h0, DEV_PREALL}, PRECHARGE_RECOVERY_CYC - 1);
        join
        check("allIdle", {7'h0, allBanksIdle}, 8'h01);
        i_sdbcs_ctrl_model.issue(CMD_PRE, 2'h3, 1'b0);
        resp("preIdle", 8'h10);
        check("b3Idle", bankState[3], BK_IDLE);
    endtask
    task automatic t_device();
        fork
            i_sdbcs_ctrl_model.issue(CMD_REF, 2'h0, 1'b0);
            hold_len("refresh", 4, {4'h0, DEV_REFRESH}, REFRESH_CYCLE_CYC - 1);
        join
        fork
            i_sdbcs_ctrl_model.issue(CMD_MODE, 2'h0, 1'b0);
            hold_len("modeLoad", 4, {4'h0, DEV_MODE}, MODE_LOAD_DELAY_CYC - 1);
        join
        check("devBack", {4'h0, deviceState}, {4'h0, DEV_READY});
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_quiet();
        t_act();
        t_bursts();
        t_stop_all();
        t_device();
        final_report();
    end
endmodule

/* verif/sdbcs_ctrl_model.sv */
// Behavioural memory controller driving the command pins
`timescale 1ns/1ps
module sdbcs_ctrl_model (
    input wire logic core_clk, // Core clock
    output logic csN, // Chip select
    output logic rasN, // Row strobe
    output logic casN, // Column strobe
    output logic weN, // Write enable
    output logic [sdbcs_pkg::ADDR_BITS-1:0] addr, // Address pins
    output logic bankLo, // Bank select low
    output logic bankHi // Bank select high
);
    import sdbcs_pkg::*;
    initial begin
        {csN, rasN, casN, weN} = 4'hF;
        addr = 12'h000;
        {bankHi, bankLo} = 2'h0;
    end
    // Only commands the bench asks for; quiet cycles between them
    // Legal order of commands is the caller's duty
    task automatic issue(input logic [3:0] c, input logic [1:0] bk, input logic ap);
        @(posedge core_clk);
        #1;
        {csN, rasN, casN, weN} = c;
        addr = {1'b0, ap, 10'h2A5};
        {bankHi, bankLo} = bk;
        @(posedge core_clk);
        #1;
        {csN, rasN, casN, weN} = CMD_NOP;
        // Lines not held at the last value once the command is gone
        addr = ~addr;
        {bankHi, bankLo} = ~bk;
    endtask
endmodule
